// ### hw/rsl_clk_loss.sv
/*
  Clock loss one-shot: restarted by every change of the sampled clock level.
  Assumes clk_level is a synchronous copy of the watched system clock.
*/
`timescale 1ns/1ps
module rsl_clk_loss import rsl_pkg::*; #(
  parameter logic [RSL_MCD_W-1:0] TIMEOUT_CYCLES = RSL_MCD_TIMEOUT[RSL_MCD_W-1:0]
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic enable,
  input  wire logic restart,
  input  wire logic clk_level,
  // Result
  output logic      expired
);

  rsl_mcd_state_t s_q;
  rsl_mcd_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.prev = clk_level;
    if (!enable || restart || (clk_level != s_q.prev)) begin
      s_d.cnt = '0;
    end else if (s_q.cnt != TIMEOUT_CYCLES) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
    s_d.expired = enable && !restart && (s_d.cnt == TIMEOUT_CYCLES); // RULE2
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign expired = s_q.expired;

endmodule

// ### hw/rsl_pkg.sv
/*
  Constants, field layout and state types of the reset source logic.
  Assumes one 100 MHz system clock and a byte-wide special-function register port.
*/
// Behaviour
// [RULE1] Low reset pin resets; bit 0 flags it
// [RULE2] Clock-edge one-shot expiry causes system reset
// [RULE3] Bit 2 reads 1 only after clock-loss reset
// [RULE4] Writing bit 2 enables or disables detector
// [RULE5] Internal resets never drive the reset pin
// [RULE6] Bit 5 enables comparator low-output reset
// [RULE7] Bit 5 reads 1 after comparator reset
// [RULE8] Software settles comparator before enabling it
// [RULE9] Watchdog enabled, clocked at clock/12 after reset
// [RULE10] Watchdog overflow resets; bit 3 flags it
// [RULE11] Flash-enabled data write above limit resets
// [RULE12] Code read or branch above limit resets
// [RULE13] Security-blocked flash access resets
// [RULE14] Flash access without high supply monitor resets
// [RULE15] Bit 6 flags flash error; read-only
// [RULE16] Writing bit 4 forces reset; flags it
// [RULE17] Writing bit 1 selects supply monitor source
// [RULE18] Bit 1 set after power-on or supply reset
// [RULE19] Software writes whole values, no read-modify-write
// [RULE20] Bit 7 reads zero, ignores writes
// [RULE21] Supply monitor resets only enabled and selected
// [RULE22] Reset sets one flag, keeps enable settings
package rsl_pkg;

  // Register location and bit layout
  localparam logic [7:0] RSL_CAUSE_ADDR = 8'hef;
  localparam int RSL_BIT_PIN  = 0;
  localparam int RSL_BIT_POR  = 1;
  localparam int RSL_BIT_MCD  = 2;
  localparam int RSL_BIT_WDT  = 3;
  localparam int RSL_BIT_SW   = 4;
  localparam int RSL_BIT_CMP  = 5;
  localparam int RSL_BIT_FERR = 6;
  localparam int RSL_NSRC     = 7;

  // Reset values of the enables kept across internal resets
  localparam logic RSL_POR_SEL_RST = 1'b1;
  localparam logic RSL_MCD_EN_RST  = 1'b0;
  localparam logic RSL_CMP_EN_RST  = 1'b0;

  // Timing counts and the reserved flash base
  localparam int RSL_HOLD_CYCLES = 16;
  localparam int RSL_HOLD_W      = 5;
  localparam int RSL_WDT_DIV     = 12;
  localparam int RSL_WDT_W       = 4;
  localparam int RSL_MCD_TIMEOUT = 32;
  localparam int RSL_MCD_W       = 8;
  localparam logic [15:0] RSL_FLASH_RSVD_BASE = 16'hfc00;

  typedef enum logic [0:0] {RSL_RUN, RSL_HOLD} rsl_phase_t;

  // Flash access attempt as seen from the core
  typedef struct packed {
    logic        write_enable;
    logic        xdata_wr;
    logic [15:0] xdata_addr;
    logic        code_rd;
    logic        branch_fetch;
    logic [15:0] code_addr;
    logic        flash_op;
    logic        secure_block;
  } rsl_flash_req_t;

  typedef struct packed {
    rsl_phase_t              phase;
    logic [RSL_HOLD_W-1:0]   hold_cnt;
    logic [RSL_NSRC-1:0]     cause;
    logic                    por_sel;
    logic                    mcd_en;
    logic                    cmp_en;
    logic                    sys_rst_n;
    logic                    pin_oe_n;
    logic                    pin_out;
    logic [7:0]              rdata;
  } rsl_state_t;

  typedef struct packed {
    logic                 prev;
    logic [RSL_MCD_W-1:0] cnt;
    logic                 expired;
  } rsl_mcd_state_t;

  typedef struct packed {
    logic [RSL_WDT_W-1:0] div;
    logic                 en;
    logic                 tick;
  } rsl_wdt_state_t;

endpackage

// ### hw/rsl_top.sv
/*
  Reset source logic: collects reset requests, holds the system in reset,
  records the cause in the reset cause register and keeps the source enables.
  Assumes synchronous inputs, a byte register port that reads with one cycle
  of latency, and that rst_n is the power-on reset of this block.
*/
`timescale 1ns/1ps
module rsl_top import rsl_pkg::*; #(
  parameter logic [15:0]          FLASH_RSVD_BASE = RSL_FLASH_RSVD_BASE,
  parameter logic [RSL_MCD_W-1:0] MCD_TIMEOUT     = RSL_MCD_TIMEOUT[RSL_MCD_W-1:0]
) (
  // Clock and power-on reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // Reset pin, open drain
  input  wire logic            rst_pin_in_n,
  output logic                 rst_pin_out,
  output logic                 rst_pin_oe_n,
  // Reset sources
  input  wire logic            clk_level,
  input  wire logic            cmp_out,
  input  wire logic            wdt_overflow,
  input  wire logic            wdt_disable_req,
  input  wire logic            vdd_mon_en,
  input  wire logic            vdd_mon_high,
  input  wire logic            vdd_low,
  input  wire rsl_flash_req_t  flash_req,
  // Register port
  input  wire logic [7:0]      sfr_addr,
  input  wire logic            sfr_wr,
  input  wire logic            sfr_rd,
  input  wire logic [7:0]      sfr_wdata,
  output logic [7:0]           sfr_rdata,
  // System outputs
  output logic                 sys_rst_n,
  output logic                 wdt_en,
  output logic                 wdt_tick
);

  rsl_state_t          s_q;
  rsl_state_t          s_d;
  logic [RSL_NSRC-1:0] hit;
  logic [RSL_NSRC-1:0] pick;
  logic                mcd_expired;
  logic                flash_err;
  logic                wr_hit;
  logic                run;

  function automatic logic in_reserved(input logic [15:0] addr);
    return addr >= FLASH_RSVD_BASE;
  endfunction

  // Fixed priority when several sources fire together
  function automatic logic [RSL_NSRC-1:0] pick_one(input logic [RSL_NSRC-1:0] h);
    logic [RSL_NSRC-1:0] p;
    p = '0;
    if (h[RSL_BIT_PIN]) begin
      p[RSL_BIT_PIN] = 1'b1;
    end else if (h[RSL_BIT_POR]) begin
      p[RSL_BIT_POR] = 1'b1;
    end else if (h[RSL_BIT_MCD]) begin
      p[RSL_BIT_MCD] = 1'b1;
    end else if (h[RSL_BIT_CMP]) begin
      p[RSL_BIT_CMP] = 1'b1;
    end else if (h[RSL_BIT_WDT]) begin
      p[RSL_BIT_WDT] = 1'b1;
    end else if (h[RSL_BIT_FERR]) begin
      p[RSL_BIT_FERR] = 1'b1;
    end else if (h[RSL_BIT_SW]) begin
      p[RSL_BIT_SW] = 1'b1;
    end
    return p;
  endfunction

  rsl_clk_loss #(
    .TIMEOUT_CYCLES (MCD_TIMEOUT)
  ) u_clk_loss (
    .clk       (clk),
    .rst_n     (rst_n),
    .enable    (s_q.mcd_en),
    .restart   (!s_q.sys_rst_n),
    .clk_level (clk_level),
    .expired   (mcd_expired)
  );

  rsl_wdt_clk u_wdt_clk (
    .clk         (clk),
    .rst_n       (rst_n),
    .sys_rst     (!s_q.sys_rst_n),
    .disable_req (wdt_disable_req),
    .wdt_en      (wdt_en),
    .wdt_tick    (wdt_tick)
  );

  assign run    = (s_q.phase == RSL_RUN);
  assign wr_hit = sfr_wr && (sfr_addr == RSL_CAUSE_ADDR);

  // Flash errors: bad write, bad read or fetch, security, weak supply guard
  assign flash_err =
      (flash_req.write_enable && flash_req.xdata_wr &&
       in_reserved(flash_req.xdata_addr)) ||                          // RULE11
      ((flash_req.code_rd || flash_req.branch_fetch) &&
       in_reserved(flash_req.code_addr)) ||                           // RULE12
      flash_req.secure_block ||                                       // RULE13
      (flash_req.flash_op &&
       !(vdd_mon_en && vdd_mon_high && s_q.por_sel));                  // RULE14

  always_comb begin
    hit = '0;
    // Own drive on the pin must not look like an external reset
    hit[RSL_BIT_PIN]  = !rst_pin_in_n && s_q.pin_oe_n;                // RULE1
    hit[RSL_BIT_POR]  = vdd_mon_en && s_q.por_sel && vdd_low;          // RULE21
    hit[RSL_BIT_MCD]  = mcd_expired;                                  // RULE2
    hit[RSL_BIT_CMP]  = s_q.cmp_en && !cmp_out;                       // RULE6
    hit[RSL_BIT_WDT]  = wdt_overflow;                                 // RULE10
    hit[RSL_BIT_FERR] = flash_err;                                    // RULE15
    hit[RSL_BIT_SW]   = wr_hit && sfr_wdata[RSL_BIT_SW];              // RULE16
    pick = pick_one(hit);
  end

  always_comb begin
    s_d = s_q;
    s_d.rdata = '0;
    if (sfr_rd && (sfr_addr == RSL_CAUSE_ADDR)) begin
      s_d.rdata = {1'b0, s_q.cause};                                  // RULE20
    end
    case (s_q.phase)
      RSL_RUN: begin
        // Bits 0, 3 and 6 are flags only; writes there are dropped
        if (wr_hit) begin
          s_d.por_sel = sfr_wdata[RSL_BIT_POR];                      // RULE17
          s_d.mcd_en  = sfr_wdata[RSL_BIT_MCD];                      // RULE4
          s_d.cmp_en  = sfr_wdata[RSL_BIT_CMP];                      // RULE6
        end
        if (|hit) begin
          s_d.phase     = RSL_HOLD;
          s_d.hold_cnt  = '0;
          s_d.cause     = pick;                                       // RULE22 RULE3 RULE7
          s_d.sys_rst_n = 1'b0;
          // Only a supply reset pulls the pin; internal ones leave it free
          s_d.pin_oe_n  = !pick[RSL_BIT_POR];                         // RULE5
        end
      end
      RSL_HOLD: begin
        if (s_q.hold_cnt != RSL_HOLD_W'(RSL_HOLD_CYCLES - 1)) begin
          s_d.hold_cnt = s_q.hold_cnt + 1'b1;
        end else if (s_q.cause[RSL_BIT_PIN] && !rst_pin_in_n) begin
          s_d.hold_cnt = s_q.hold_cnt;                                // RULE1
        end else if (s_q.cause[RSL_BIT_POR] && vdd_mon_en && vdd_low) begin
          s_d.hold_cnt = s_q.hold_cnt;                                // RULE18
        end else begin
          s_d.phase     = RSL_RUN;
          s_d.sys_rst_n = 1'b1;
          s_d.pin_oe_n  = 1'b1;
        end
      end
      default: begin
        s_d.phase = RSL_RUN;
      end
    endcase
  end

  // Power-on: hold in reset, drive the pin, flag only the supply bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{phase:     RSL_HOLD,
               hold_cnt:  '0,
               cause:     RSL_NSRC'(1 << RSL_BIT_POR),               // RULE18
               por_sel:   RSL_POR_SEL_RST,
               mcd_en:    RSL_MCD_EN_RST,
               cmp_en:    RSL_CMP_EN_RST,
               sys_rst_n: 1'b0,
               pin_oe_n:  1'b0,
               pin_out:   1'b0,
               rdata:     '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign rst_pin_out  = s_q.pin_out;
  assign rst_pin_oe_n = s_q.pin_oe_n;
  assign sfr_rdata    = s_q.rdata;
  assign sys_rst_n    = s_q.sys_rst_n;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_pin_reset;
    run && !rst_pin_in_n && rst_pin_oe_n |=> !sys_rst_n && s_q.cause == 7'h01;
  endproperty
  a_pin_reset: assert property (p_pin_reset) // RULE1
    else $error("Pin reset not taken");

  property p_mcd_reset;
    run && pick[RSL_BIT_MCD] |=> !sys_rst_n && s_q.cause == 7'h04;
  endproperty
  a_mcd_reset: assert property (p_mcd_reset) // RULE3
    else $error("Clock loss reset cause wrong");

  property p_mcd_disabled;
    !s_q.mcd_en && !$past(s_q.mcd_en) |-> !mcd_expired;
  endproperty
  a_mcd_disabled: assert property (p_mcd_disabled) // RULE2
    else $error("Clock loss fired while disabled");

  property p_mcd_enable_write;
    run && wr_hit |=> s_q.mcd_en == $past(sfr_wdata[RSL_BIT_MCD]);
  endproperty
  a_mcd_enable_write: assert property (p_mcd_enable_write) // RULE4
    else $error("Clock loss enable not written");

  property p_pin_not_driven;
    !rst_pin_oe_n |-> s_q.cause == 7'h02 && !sys_rst_n;
  endproperty
  a_pin_not_driven: assert property (p_pin_not_driven) // RULE5
    else $error("Pin driven for internal reset");

  property p_cmp_reset;
    run && s_q.cmp_en && !cmp_out |=> !sys_rst_n;
  endproperty
  a_cmp_reset: assert property (p_cmp_reset) // RULE6
    else $error("Comparator reset missed");

  property p_cmp_flag;
    run && pick[RSL_BIT_CMP] |=> s_q.cause == 7'h20;
  endproperty
  a_cmp_flag: assert property (p_cmp_flag) // RULE7
    else $error("Comparator cause wrong");

  property p_wdt_after_reset;
    $rose(sys_rst_n) |-> wdt_en ##12 (wdt_tick || !wdt_en || !sys_rst_n);
  endproperty
  a_wdt_after_reset: assert property (p_wdt_after_reset) // RULE9
    else $error("Watchdog not armed after reset");

  property p_wdt_reset;
    run && pick[RSL_BIT_WDT] |=> !sys_rst_n && s_q.cause == 7'h08;
  endproperty
  a_wdt_reset: assert property (p_wdt_reset) // RULE10
    else $error("Watchdog reset cause wrong");

  property p_flash_write_err;
    run && flash_req.write_enable && flash_req.xdata_wr &&
      flash_req.xdata_addr >= FLASH_RSVD_BASE |=> !sys_rst_n;
  endproperty
  a_flash_write_err: assert property (p_flash_write_err) // RULE11
    else $error("Reserved flash write not reset");

  property p_flash_flag_ro;
    run && wr_hit && !(|hit) |=> $stable(s_q.cause);
  endproperty
  a_flash_flag_ro: assert property (p_flash_flag_ro) // RULE15
    else $error("Write changed cause flags");

  property p_sw_force;
    run && wr_hit && sfr_wdata[RSL_BIT_SW] && hit == 7'h10
      |=> !sys_rst_n && s_q.cause == 7'h10 ##15 !sys_rst_n ##1 sys_rst_n && s_q.cause == 7'h10;
  endproperty
  a_sw_force: assert property (p_sw_force) // RULE16
    else $error("Software reset not forced");

  property p_bit7_zero;
    sfr_rdata[7] == 1'b0;
  endproperty
  a_bit7_zero: assert property (p_bit7_zero) // RULE20
    else $error("Unused bit read nonzero");

  property p_enables_kept;
    !run && !$past(run) |-> $stable({s_q.por_sel, s_q.mcd_en, s_q.cmp_en});
  endproperty
  a_enables_kept: assert property (p_enables_kept) // RULE22
    else $error("Enable changed during reset");

  property p_flash_read_err;
    run && (flash_req.code_rd || flash_req.branch_fetch) &&
      flash_req.code_addr >= FLASH_RSVD_BASE |=> !sys_rst_n;
  endproperty
  a_flash_read_err: assert property (p_flash_read_err) // RULE12
    else $error("Reserved code read not reset");

  property p_flash_secure;
    run && flash_req.secure_block |=> !sys_rst_n;
  endproperty
  a_flash_secure: assert property (p_flash_secure) // RULE13
    else $error("Secured flash access not reset");

  property p_flash_supply;
    run && flash_req.flash_op &&
      !(vdd_mon_en && vdd_mon_high && s_q.por_sel) |=> !sys_rst_n;
  endproperty
  a_flash_supply: assert property (p_flash_supply) // RULE14
    else $error("Unguarded flash access not reset");

  property p_ferr_flag;
    run && pick[RSL_BIT_FERR] |=> s_q.cause == 7'h40;
  endproperty
  a_ferr_flag: assert property (p_ferr_flag) // RULE15
    else $error("Flash error cause wrong");

  property p_por_select_write;
    run && wr_hit |=> s_q.por_sel == $past(sfr_wdata[RSL_BIT_POR]);
  endproperty
  a_por_select_write: assert property (p_por_select_write) // RULE17
    else $error("Supply select not written");

  property p_cmp_enable_write;
    run && wr_hit |=> s_q.cmp_en == $past(sfr_wdata[RSL_BIT_CMP]);
  endproperty
  a_cmp_enable_write: assert property (p_cmp_enable_write) // RULE6
    else $error("Comparator enable not written");

  // Pin request outranks the supply, so it is left out here
  property p_supply_reset;
    run && vdd_mon_en && s_q.por_sel && vdd_low && !hit[RSL_BIT_PIN]
      |=> !sys_rst_n && s_q.cause == 7'h02;
  endproperty
  a_supply_reset: assert property (p_supply_reset) // RULE21
    else $error("Supply reset not taken");

  property p_supply_hold;
    !run && s_q.cause[RSL_BIT_POR] && vdd_mon_en && vdd_low |=> !sys_rst_n;
  endproperty
  a_supply_hold: assert property (p_supply_hold) // RULE18
    else $error("Released while supply low");

  property p_pin_hold;
    !run && s_q.cause[RSL_BIT_PIN] && !rst_pin_in_n |=> !sys_rst_n;
  endproperty
  a_pin_hold: assert property (p_pin_hold) // RULE1
    else $error("Released while pin low");

  property p_mcd_flag_clear;
    run && (|hit) && !pick[RSL_BIT_MCD] |=> !s_q.cause[RSL_BIT_MCD];
  endproperty
  a_mcd_flag_clear: assert property (p_mcd_flag_clear) // RULE3
    else $error("Clock loss flag left set");

  property p_wdt_armed;
    !sys_rst_n |=> wdt_en;
  endproperty
  a_wdt_armed: assert property (p_wdt_armed) // RULE9
    else $error("Watchdog not enabled in reset");

  property p_pin_released;
    run && (|hit) && !pick[RSL_BIT_POR] |=> rst_pin_oe_n;
  endproperty
  a_pin_released: assert property (p_pin_released) // RULE5
    else $error("Pin driven for internal reset");

endmodule

// ### hw/rsl_wdt_clk.sv
/*
  Watchdog enable and clock/12 tick generator, re-armed by every system reset.
  Assumes the watchdog counter itself lives outside and counts on tick.
*/
`timescale 1ns/1ps
module rsl_wdt_clk import rsl_pkg::*; (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic sys_rst,
  input  wire logic disable_req,
  // Outputs
  output logic      wdt_en,
  output logic      wdt_tick
);

  rsl_wdt_state_t s_q;
  rsl_wdt_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (sys_rst) begin
      s_d.en  = 1'b1; // RULE9
      s_d.div = '0;
    end else begin
      if (disable_req) begin
        s_d.en = 1'b0;
      end
      if (s_q.div == RSL_WDT_W'(RSL_WDT_DIV - 1)) begin
        s_d.div  = '0;
        s_d.tick = s_d.en; // RULE9
      end else begin
        s_d.div = s_q.div + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{div: '0, en: 1'b1, tick: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign wdt_en   = s_q.en;
  assign wdt_tick = s_q.tick;

endmodule

// ### tb/rsl_pin_model.sv
/*
  Reset pin as seen on the board: open-drain wire with a pull-up,
  pulled low by the device or by external reset circuitry.
  Assumes the device drives only while its enable is low.
*/
`timescale 1ns/1ps
module rsl_pin_model (
  // Device side
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  // Board side
  input  wire logic ext_low,
  // Wire level
  output logic      pin_n
);
  // Pull-up wins when nobody pulls low
  assign pin_n = (ext_low || (!pin_oe_n && !pin_out)) ? 1'b0 : 1'b1;
endmodule

// ### tb/test_reset_source_logic.sv
/*
  Self-checking bench of the reset source logic: register port tasks,
  reset source stimulus and expected cause values.
  Assumes the block's embedded assertions watch the internal timing.
*/
`timescale 1ns/1ps
module test_reset_source_logic import rsl_pkg::*;;
  logic           clk, rst_n, ext_low, clk_level, tog, cmp_out;
  logic           wdt_overflow, wdt_disable_req, vdd_mon_en, vdd_mon_high, vdd_low;
  logic           sfr_wr, sfr_rd, rst_pin_in_n, rst_pin_out, rst_pin_oe_n;
  logic           sys_rst_n, wdt_en, wdt_tick;
  logic [7:0]     sfr_addr, sfr_wdata, sfr_rdata;
  rsl_flash_req_t flash_req;
  int             n_fail, n_compared;

  rsl_top #(.MCD_TIMEOUT(8'h04)) rsl_top_i (
    .clk(clk), .rst_n(rst_n), .rst_pin_in_n(rst_pin_in_n), .rst_pin_out(rst_pin_out),
    .rst_pin_oe_n(rst_pin_oe_n), .clk_level(clk_level), .cmp_out(cmp_out),
    .wdt_overflow(wdt_overflow), .wdt_disable_req(wdt_disable_req),
    .vdd_mon_en(vdd_mon_en), .vdd_mon_high(vdd_mon_high), .vdd_low(vdd_low),
    .flash_req(flash_req), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sys_rst_n(sys_rst_n),
    .wdt_en(wdt_en), .wdt_tick(wdt_tick));

  rsl_pin_model rsl_pin_model_i (.pin_out(rst_pin_out), .pin_oe_n(rst_pin_oe_n),
    .ext_low(ext_low), .pin_n(rst_pin_in_n));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Watched clock keeps changing unless a test stops it
  always @(posedge clk) begin
    if (tog) clk_level <= ~clk_level;
  end

  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1;
    chk("sfr_rdata", exp, sfr_rdata);
  endtask

  // Bounded wait for the system to enter reset
  task automatic wait_lo(input int n);
    int i;
    for (i = 0; i < n && sys_rst_n !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    chk("reset_entered", 8'h00, {7'h00, sys_rst_n});
    if (sys_rst_n !== 1'b0) conclude();
  endtask

  // Bounded wait for release; the pin enable is watched all through the hold
  task automatic wait_run(input logic oe_n);
    int i;
    for (i = 0; i < 400 && sys_rst_n !== 1'b1; i++) begin
      chk("rst_pin_oe_n", {7'h00, oe_n}, {7'h00, rst_pin_oe_n});
      @(posedge clk);
      #1;
    end
    chk("reset_left", 8'h01, {7'h00, sys_rst_n});
    if (sys_rst_n !== 1'b1) conclude();
  endtask

  task automatic no_reset(input int n);
    logic ok;
    ok = 1'b1;
    repeat (n) begin
      @(posedge clk);
      #1;
      ok = ok & sys_rst_n;
    end
    chk("no_reset", 8'h01, {7'h00, ok});
  endtask

  task automatic tick_gap;
    int i;
    int g;
    for (i = 0; i < 30 && wdt_tick !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    g = 0;
    do begin
      @(posedge clk);
      #1;
      g++;
    end while (wdt_tick !== 1'b1 && g < 30);
    chk("wdt_tick_gap", 8'(RSL_WDT_DIV), 8'(g));
  endtask

  // Strobe bits: 7 write enable, 6 data write, 4 code read, 3 branch, 1 flash op, 0 secure
  function automatic rsl_flash_req_t fq(input logic [7:0] s, input logic [15:0] a);
    return '{s[7], s[6], a, s[4], s[3], a, s[1], s[0]};
  endfunction

  task automatic fl_err(input rsl_flash_req_t r, input logic hi);
    @(posedge clk);
    flash_req <= r;
    vdd_mon_high <= hi;
    @(posedge clk);
    flash_req <= '0;
    wait_lo(4);
    vdd_mon_high <= 1'b1;
    wait_run(1'b1);
    rd(RSL_CAUSE_ADDR, 8'h40);
  endtask

  task automatic fl_ok(input rsl_flash_req_t r);
    @(posedge clk);
    flash_req <= r;
    @(posedge clk);
    flash_req <= '0;
    no_reset(8);
  endtask

  initial begin
    {rst_n, ext_low, cmp_out, wdt_overflow, wdt_disable_req} = 5'b00100;
    {vdd_mon_en, vdd_mon_high, vdd_low, sfr_wr, sfr_rd} = 5'b11000;
    {clk_level, tog} = 2'b01;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    flash_req = '0;
    n_fail = 0;
    n_compared = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    wait_run(1'b0);
    rd(RSL_CAUSE_ADDR, 8'h02);
    chk("wdt_en", 8'h01, {7'h00, wdt_en});
    tick_gap();
    rd(8'hee, 8'h00);
    wr(8'hee, 8'h10);
    no_reset(8);
    wr(RSL_CAUSE_ADDR, 8'hc8);
    no_reset(8);
    rd(RSL_CAUSE_ADDR, 8'h02);
    // Software reset brings the watchdog back after it was turned off
    @(posedge clk);
    wdt_disable_req <= 1'b1;
    @(posedge clk);
    wdt_disable_req <= 1'b0;
    no_reset(2);
    chk("wdt_en", 8'h00, {7'h00, wdt_en});
    wr(RSL_CAUSE_ADDR, 8'h12);
    wait_lo(4);
    wait_run(1'b1);
    rd(RSL_CAUSE_ADDR, 8'h10);
    chk("wdt_en", 8'h01, {7'h00, wdt_en});
    @(posedge clk);
    wdt_overflow <= 1'b1;
    @(posedge clk);
    wdt_overflow <= 1'b0;
    wait_lo(4);
    wait_run(1'b1);
    rd(RSL_CAUSE_ADDR, 8'h08);
    @(posedge clk);
    ext_low <= 1'b1;
    wait_lo(4);
    repeat (20) @(posedge clk);
    ext_low <= 1'b0;
    wait_run(1'b1);
    rd(RSL_CAUSE_ADDR, 8'h01);
    // Comparator already settled high before its enable is written
    wr(RSL_CAUSE_ADDR, 8'h22);
    no_reset(10);
    repeat (2) begin
      cmp_out <= 1'b0;
      wait_lo(4);
      cmp_out <= 1'b1;
      wait_run(1'b1);
      rd(RSL_CAUSE_ADDR, 8'h20);
    end
    wr(RSL_CAUSE_ADDR, 8'h02);
    cmp_out <= 1'b0;
    no_reset(10);
    cmp_out <= 1'b1;
    wr(RSL_CAUSE_ADDR, 8'h06);
    no_reset(20);
    tog <= 1'b0;
    wait_lo(10);
    tog <= 1'b1;
    wait_run(1'b1);
    rd(RSL_CAUSE_ADDR, 8'h04);
    wr(RSL_CAUSE_ADDR, 8'h02);
    tog <= 1'b0;
    no_reset(20);
    tog <= 1'b1;
    fl_err(fq(8'hc0, 16'hfc00), 1'b1);
    fl_err(fq(8'h10, 16'hffff), 1'b1);
    fl_err(fq(8'h08, 16'hfc00), 1'b1);
    fl_err(fq(8'h01, 16'h0000), 1'b1);
    fl_err(fq(8'h02, 16'h0000), 1'b0);
    fl_ok(fq(8'hc0, 16'hfbff));
    fl_ok(fq(8'h40, 16'hfc00));
    fl_ok(fq(8'h18, 16'hfbff));
    fl_ok(fq(8'h02, 16'h0000));
    wr(RSL_CAUSE_ADDR, 8'h00);
    vdd_low <= 1'b1;
    no_reset(8);
    vdd_mon_en <= 1'b0;
    wr(RSL_CAUSE_ADDR, 8'h02);
    no_reset(8);
    vdd_mon_en <= 1'b1;
    wait_lo(4);
    repeat (10) @(posedge clk);
    chk("rst_pin_in_n", 8'h00, {7'h00, rst_pin_in_n});
    vdd_low <= 1'b0;
    wait_run(1'b0);
    rd(RSL_CAUSE_ADDR, 8'h02);
    conclude();
  end
endmodule
